// ===== rtl/ssq_sequencer.v
// Measurement sequencer with warm-up, dummy, auto-offset, temperature ratio and shared memory supervision.
`timescale 1ns/1ps
`include "ssq_defs.vh"

module ssq_sequencer #(
   parameter DATA_W = 24,
   parameter TIME_W = 16
) (
   input wire clk_sys,
   input wire rstn,
   input wire [3:0] reg_addr,
   input wire [23:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [23:0] reg_rdata,
   input wire start_measure_opcode,
   input wire init_opcode,
   output reg meas_start,
   output reg meas_with_temp,
   output reg post_process_en,
   input wire meas_done,
   input wire [DATA_W-1:0] meas_value,
   input wire [TIME_W-1:0] disch_time,
   input wire [TIME_W-1:0] temp_sensor_time,
   input wire [TIME_W-1:0] temp_ref_time,
   input wire first_arith_ram_req,
   input wire second_arith_ram_req,
   output wire [1:0] first_arith_speed,
   output wire [1:0] second_arith_speed,
   output wire speed_unsupported,
   output wire irq
);

   // Shortest resolvable discharge time in clock cycles, rounded up.
   localparam [TIME_W-1:0] TMIN_CYC = (`SSQ_TDC_MIN_NS + `SSQ_CLK_PERIOD_NS - 1) / `SSQ_CLK_PERIOD_NS;
   localparam ACC_W = DATA_W + 7;

   // Sequencer states.
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_START = 3'h1;
   localparam [2:0] S_WAIT = 3'h2;
   localparam [2:0] S_DIV = 3'h3;
   localparam [2:0] S_NEXT = 3'h4;

   // Phases after init.
   localparam [1:0] P_WARM = 2'h0;
   localparam [1:0] P_DUMMY = 2'h1;
   localparam [1:0] P_OFFS = 2'h2;
   localparam [1:0] P_RUN = 2'h3;

   // Warm-up cycle count from its three-bit field.
   function [10:0] warm_cycles;
      input [2:0] f;
      begin
         if (f == 3'h0) begin
            warm_cycles = 11'h000;
         end else begin
            warm_cycles = 11'h010 << (f - 3'h1);
         end
      end
   endfunction

   // Dummy measurement count from its two-bit field.
   function [10:0] dummy_cycles;
      input [1:0] f;
      begin
         dummy_cycles = (f == 2'h3) ? 11'h004 : {9'h000, f};
      end
   endfunction

   reg [23:0] cfg0_reg;
   reg [23:0] cfg2_reg;
   reg [15:0] temp_reg;
   reg conflict_reg;
   reg [DATA_W-1:0] result_reg;
   reg [DATA_W-1:0] offset_reg;
   reg [3:0] irq_status_reg;
   reg [3:0] irq_mask_reg;
   reg [2:0] state_reg;
   reg [1:0] phase_reg;
   reg [10:0] cnt_reg;
   reg [ACC_W-1:0] acc_reg;
   reg [3:0] trate_cnt_reg;
   reg run_active_reg;
   reg [29:0] dividend_reg;
   reg [TIME_W:0] rem_reg;
   reg [15:0] quot_reg;
   reg [4:0] div_cnt_reg;
   reg div_sat_reg;
   reg [TIME_W-1:0] ref_reg;
   reg [3:0] ev_set;

   wire single_conv = cfg0_reg[`SSQ_CFG0_SINGLE_BIT];
   wire [1:0] trate = cfg0_reg[`SSQ_CFG0_TRATE_LSB +: 2];
   wire offs_en = cfg0_reg[`SSQ_CFG0_OFFSUB_BIT];
   wire [2:0] avg_f = cfg2_reg[`SSQ_CFG2_AVG_LSB +: 3];
   wire [2:0] warm_f = cfg2_reg[`SSQ_CFG2_WARM_LSB +: 3];
   wire [1:0] dummy_f = cfg2_reg[`SSQ_CFG2_DUMMY_LSB +: 2];
   wire [10:0] avg_count = 11'h001 << avg_f;
   wire [ACC_W-1:0] meas_ext = {{7{meas_value[DATA_W-1]}}, meas_value};
   wire [ACC_W-1:0] acc_sum = acc_reg + meas_ext;
   wire [ACC_W-1:0] acc_avg = $signed(acc_sum) >>> avg_f;
   wire [TIME_W:0] rem_shift = {rem_reg[TIME_W-1:0], dividend_reg[29]};
   wire rem_ge = rem_shift >= {1'b0, ref_reg};

   assign first_arith_speed = cfg0_reg[`SSQ_CFG0_SPEED1_LSB +: 2];
   assign second_arith_speed = cfg0_reg[`SSQ_CFG0_SPEED2_LSB +: 2];
   assign speed_unsupported = (first_arith_speed == 2'h0) || (second_arith_speed == 2'h0);

   // Level interrupt from unmasked sticky status bits.
   assign irq = |(irq_status_reg & irq_mask_reg);

   wire temp_now = (trate == 2'h1) || (trate == 2'h2 && trate_cnt_reg == 4'h0) ||
                   (trate == 2'h3 && trate_cnt_reg == 4'h0);
   wire [3:0] trate_wrap = (trate == 2'h2) ? 4'h5 : 4'h8;

   // Configuration writes; speed fields reset to option 1.
   always @(posedge clk_sys) begin
      if (!rstn) begin
         cfg0_reg <= `SSQ_CFG0_RESET;
         cfg2_reg <= `SSQ_CFG2_RESET;
         irq_mask_reg <= 4'h0;
      end else if (reg_wr) begin
         if (reg_addr == `SSQ_ADDR_CFG0) begin
            cfg0_reg <= reg_wdata;
         end
         if (reg_addr == `SSQ_ADDR_CFG2) begin
            cfg2_reg <= reg_wdata;
         end
         if (reg_addr == `SSQ_ADDR_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[3:0];
         end
      end
   end

   // Read data stands in the cycle after the read strobe; unmapped reads give zero.
   always @(posedge clk_sys) begin
      if (!rstn) begin
         reg_rdata <= 24'h000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SSQ_ADDR_CFG0: reg_rdata <= cfg0_reg;
            `SSQ_ADDR_CFG2: reg_rdata <= {4'h0, conflict_reg, 3'h0, temp_reg};
            `SSQ_ADDR_RESULT: reg_rdata <= result_reg;
            `SSQ_ADDR_OFFSET: reg_rdata <= offset_reg;
            `SSQ_ADDR_IRQ_STATUS: reg_rdata <= {20'h00000, irq_status_reg};
            `SSQ_ADDR_IRQ_MASK: reg_rdata <= {20'h00000, irq_mask_reg};
            default: reg_rdata <= 24'h000000;
         endcase
      end else begin
         reg_rdata <= 24'h000000;
      end
   end

   // Sticky status: a new event wins over the clearing read.
   always @(posedge clk_sys) begin
      if (!rstn) begin
         irq_status_reg <= 4'h0;
      end else if (reg_rd && reg_addr == `SSQ_ADDR_IRQ_STATUS) begin
         irq_status_reg <= ev_set;
      end else begin
         irq_status_reg <= irq_status_reg | ev_set;
      end
   end

   wire ram_clash = first_arith_ram_req && second_arith_ram_req;

   always @(posedge clk_sys) begin
      if (!rstn || init_opcode) begin
         conflict_reg <= 1'b0;
      end else if (ram_clash) begin
         conflict_reg <= 1'b1;
      end
   end

   // Event pulses gathered for the status register.
   always @* begin
      ev_set = 4'h0;
      ev_set[`SSQ_IRQ_CONFLICT_BIT] = ram_clash;
      if (state_reg == S_WAIT && meas_done) begin
         ev_set[`SSQ_IRQ_TIMEOUT_BIT] = disch_time < TMIN_CYC;
         ev_set[`SSQ_IRQ_DONE_BIT] = (disch_time >= TMIN_CYC) && (phase_reg == P_RUN);
         ev_set[`SSQ_IRQ_OFFSET_BIT] = (disch_time >= TMIN_CYC) && (phase_reg == P_OFFS) &&
                                      (cnt_reg == 11'h001) && !single_conv;
      end
   end

   // Main sequence: phases, measurement launch, completion and temperature division.
   always @(posedge clk_sys) begin
      meas_start <= 1'b0;
      if (!rstn || init_opcode) begin
         state_reg <= S_IDLE;
         phase_reg <= P_WARM;
         cnt_reg <= 11'h000;
         run_active_reg <= 1'b0;
         acc_reg <= {ACC_W{1'b0}};
         trate_cnt_reg <= 4'h0;
         meas_with_temp <= 1'b0;
         post_process_en <= 1'b0;
         div_cnt_reg <= 5'h00;
         dividend_reg <= 30'h00000000;
         rem_reg <= {(TIME_W+1){1'b0}};
         quot_reg <= 16'h0000;
         div_sat_reg <= 1'b0;
         if (!rstn) begin
            offset_reg <= {DATA_W{1'b0}};
            result_reg <= {DATA_W{1'b0}};
            temp_reg <= 16'h0000;
         end
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (start_measure_opcode) begin
                  state_reg <= S_START;
                  if (!run_active_reg) begin
                     cnt_reg <= warm_cycles(warm_f);
                     run_active_reg <= 1'b1;
                  end
               end
            end
            S_START: begin
               case (phase_reg)
                  P_WARM: begin
                     if (cnt_reg == 11'h000) begin
                        phase_reg <= P_DUMMY;
                        cnt_reg <= dummy_cycles(dummy_f);
                     end else begin
                        meas_start <= 1'b1;
                        meas_with_temp <= 1'b0;
                        post_process_en <= 1'b0;
                        state_reg <= S_WAIT;
                     end
                  end
                  P_DUMMY: begin
                     if (cnt_reg == 11'h000) begin
                        phase_reg <= offs_en ? P_OFFS : P_RUN;
                        cnt_reg <= avg_count;
                        acc_reg <= {ACC_W{1'b0}};
                     end else begin
                        meas_start <= 1'b1;
                        meas_with_temp <= 1'b0;
                        post_process_en <= 1'b0;
                        state_reg <= S_WAIT;
                     end
                  end
                  default: begin
                     meas_start <= 1'b1;
                     meas_with_temp <= (phase_reg == P_RUN) && temp_now;
                     post_process_en <= 1'b1;
                     state_reg <= S_WAIT;
                  end
               endcase
            end
            S_WAIT: begin
               if (meas_done) begin
                  state_reg <= S_NEXT;
                  if (phase_reg != P_RUN) begin
                     cnt_reg <= cnt_reg - 11'h001;
                  end
                  if (disch_time < TMIN_CYC) begin
                     state_reg <= S_NEXT;
                  end else if (phase_reg == P_OFFS) begin
                     acc_reg <= acc_sum;
                     if (cnt_reg == 11'h001) begin
                        offset_reg <= acc_avg[DATA_W-1:0];
                        phase_reg <= P_RUN;
                     end
                  end else if (phase_reg == P_RUN) begin
                     result_reg <= offs_en ? meas_value - offset_reg : meas_value;
                     if (trate != 2'h0) begin
                        trate_cnt_reg <= (trate_cnt_reg >= trate_wrap) ? 4'h0 : trate_cnt_reg + 4'h1;
                     end
                     if (meas_with_temp) begin
                        state_reg <= S_DIV;
                        dividend_reg <= {temp_sensor_time, 14'h0000};
                        rem_reg <= {(TIME_W+1){1'b0}};
                        ref_reg <= temp_ref_time; // Reference time is valid only in the done cycle.
                        div_cnt_reg <= 5'h1E;
                        div_sat_reg <= (temp_ref_time == {TIME_W{1'b0}}) ||
                                       (temp_sensor_time[TIME_W-1:2] >= temp_ref_time);
                     end
                  end
               end
            end
            S_DIV: begin
               // sensor over reference ratio, fourteen fraction bits
               rem_reg <= rem_ge ? rem_shift - {1'b0, ref_reg} : rem_shift;
               quot_reg <= {quot_reg[14:0], rem_ge};
               dividend_reg <= {dividend_reg[28:0], 1'b0};
               div_cnt_reg <= div_cnt_reg - 5'h01;
               if (div_cnt_reg == 5'h01) begin
                  temp_reg <= div_sat_reg ? 16'hFFFF : {quot_reg[14:0], rem_ge};
                  state_reg <= S_NEXT;
               end
            end
            S_NEXT: begin
               post_process_en <= 1'b0;
               meas_with_temp <= 1'b0;
               // single mode waits for host start on offset and real measurements
               if (single_conv && (phase_reg == P_OFFS || phase_reg == P_RUN)) begin
                  state_reg <= S_IDLE;
               end else begin
                  state_reg <= S_START;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule // ssq_sequencer

// ===== rtl/ssq_defs.vh
// Register offsets, field positions, reset values and timing figures of the strain measurement sequencer.
`ifndef SSQ_DEFS_VH
`define SSQ_DEFS_VH

// Register addresses on the plain register port.
`define SSQ_ADDR_CFG0 4'h0
`define SSQ_ADDR_CFG2 4'h2
`define SSQ_ADDR_RESULT 4'h3
`define SSQ_ADDR_OFFSET 4'h4
`define SSQ_ADDR_IRQ_STATUS 4'h5
`define SSQ_ADDR_IRQ_MASK 4'h6

// Configuration register 0 fields.
`define SSQ_CFG0_SINGLE_BIT 0
`define SSQ_CFG0_TRATE_LSB 1
`define SSQ_CFG0_OFFSUB_BIT 7
`define SSQ_CFG0_SPEED1_LSB 8
`define SSQ_CFG0_SPEED2_LSB 10
`define SSQ_CFG0_RESET 24'h000502

// Configuration register 2 fields.
`define SSQ_CFG2_AVG_LSB 4
`define SSQ_CFG2_WARM_LSB 8
`define SSQ_CFG2_DUMMY_LSB 12
`define SSQ_CFG2_RESET 24'h000000

// Status register 2 fields: temperature ratio and shared memory conflict.
`define SSQ_STAT2_CONFLICT_BIT 19
`define SSQ_TEMP_FRAC_BITS 14

// Interrupt status bits.
`define SSQ_IRQ_DONE_BIT 0
`define SSQ_IRQ_TIMEOUT_BIT 1
`define SSQ_IRQ_CONFLICT_BIT 2
`define SSQ_IRQ_OFFSET_BIT 3

// Timing figures.
`define SSQ_CLK_PERIOD_NS 100
`define SSQ_TDC_MIN_NS 1500

`endif

// ===== verif/ssq_sequencer_assertions.sv
// Port-level concurrent checks of the strain measurement sequencer.
`timescale 1ns/1ps
module ssq_sequencer_checker (
   input wire clk_sys,
   input wire rstn,
   input wire [3:0] reg_addr,
   input wire [23:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [23:0] reg_rdata,
   input wire init_opcode,
   input wire meas_start,
   input wire meas_with_temp,
   input wire first_arith_ram_req,
   input wire second_arith_ram_req,
   input wire [1:0] first_arith_speed,
   input wire [1:0] second_arith_speed,
   input wire speed_unsupported,
   input wire irq
);
   reg [1:0] rate_reg;
   reg [3:0] mask_reg;
   reg [7:0] quiet_reg;
   // Shadows of the rate field and mask, and cycles since the last write to configuration register 0.
   always @(posedge clk_sys) begin
      if (!rstn) begin
         rate_reg <= 2'h1;
         mask_reg <= 4'h0;
         quiet_reg <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == 4'h6) mask_reg <= reg_wdata[3:0];
         if (reg_wr && reg_addr == 4'h0) rate_reg <= reg_wdata[2:1];
         quiet_reg <= (reg_wr && reg_addr == 4'h0) ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'hFF};
      end
   end
   // All checks run on the system clock and rest during reset.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 24'h000000)
      else $error("read data not zero outside a read answer");
   a_read_unmapped: assert property (reg_rd && (reg_addr == 4'h1 || reg_addr > 4'h6) |=> reg_rdata == 24'h000000)
      else $error("unmapped read returned data");
   a_mask_readback: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata[3:0] == mask_reg)
      else $error("mask read back wrong");
   a_speed_reset: assert property (!$past(rstn) |-> first_arith_speed == 2'h1 && second_arith_speed == 2'h1)
      else $error("speed options not 1 after reset");
   a_speed_flag: assert property (speed_unsupported == (first_arith_speed == 2'h0 || second_arith_speed == 2'h0))
      else $error("unsupported speed flag wrong");
   a_start_pulse: assert property (meas_start |=> !meas_start)
      else $error("launch pulse longer than one cycle");
   a_rate_off: assert property (meas_start && rate_reg == 2'h0 && quiet_reg > 8'h64 |-> !meas_with_temp)
      else $error("temperature measured with rate off");
   a_conflict_flag: assert property (first_arith_ram_req && second_arith_ram_req && !init_opcode ##1
      reg_rd && reg_addr == 4'h2 && !init_opcode |=> reg_rdata[19])
      else $error("memory conflict not flagged");
   a_irq_masked: assert property (irq |-> mask_reg != 4'h0)
      else $error("interrupt with all sources masked");
   // Main scenarios.
   c_launch: cover property (meas_start);
   c_irq: cover property ($rose(irq));
   c_conflict: cover property (first_arith_ram_req && second_arith_ram_req);
endmodule // ssq_sequencer_checker
bind ssq_sequencer ssq_sequencer_checker u_chk (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .init_opcode, .meas_start, .meas_with_temp, .first_arith_ram_req, .second_arith_ram_req,
   .first_arith_speed, .second_arith_speed, .speed_unsupported, .irq);

// ===== verif/ssq_meas_model.sv
// Behavioural measurement front end answering each launch after a fixed latency.
`timescale 1ns/1ps
module ssq_meas_model (
   input wire clk_sys,
   input wire rstn,
   input wire init_opcode,
   input wire meas_start,
   input wire meas_with_temp,
   input wire post_process_en,
   input wire [23:0] val,
   input wire [15:0] dis,
   input wire [15:0] ts,
   input wire [15:0] tr,
   output reg meas_done = 1'b0,
   output reg [23:0] meas_value = 24'h000000,
   output reg [15:0] disch_time = 16'h0000,
   output reg [15:0] temp_sensor_time = 16'h0000,
   output reg [15:0] temp_ref_time = 16'h0000,
   output reg [15:0] n_start = 16'h0000,
   output reg [15:0] n_nopost = 16'h0000,
   output reg [15:0] n_post = 16'h0000,
   output reg [15:0] n_temp = 16'h0000
);
   reg [3:0] cnt_reg = 4'h0;
   reg busy_reg = 1'b0;
   // Data lines toggle outside the done cycle so a stale value never matches.
   always @(posedge clk_sys) begin
      meas_done <= 1'b0;
      meas_value <= ~meas_value;
      disch_time <= ~disch_time;
      temp_sensor_time <= ~temp_sensor_time;
      temp_ref_time <= ~temp_ref_time;
      if (!rstn || init_opcode) begin
         busy_reg <= 1'b0;
         n_start <= 16'h0000;
         n_nopost <= 16'h0000;
      end else if (meas_start) begin
         busy_reg <= 1'b1;
         cnt_reg <= 4'h6;
         n_start <= n_start + 16'h0001;
      end else if (busy_reg && cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
      end else if (busy_reg) begin
         busy_reg <= 1'b0;
         meas_done <= 1'b1;
         meas_value <= val;
         disch_time <= dis;
         temp_sensor_time <= ts;
         temp_ref_time <= tr;
         n_post <= n_post + {15'h0000, post_process_en};
         n_nopost <= n_nopost + {15'h0000, !post_process_en};
         n_temp <= n_temp + {15'h0000, post_process_en && meas_with_temp};
      end
   end
endmodule // ssq_meas_model

// ===== verif/ssq_sequencer_test.sv
// Self-checking bench of the strain measurement sequencer.
`timescale 1ns/1ps
module ssq_sequencer_test;
   reg clk_sys = 1'b0;
   reg rstn = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [23:0] reg_wdata = 24'h000000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg start_op = 1'b0;
   reg init_op = 1'b0;
   reg [1:0] ram_req = 2'h0;
   reg [23:0] m_val = 24'h000100;
   reg [15:0] m_dis = 16'h0064;
   reg [15:0] m_ts = 16'h1000;
   reg [23:0] q;
   wire [23:0] reg_rdata, meas_value;
   wire [15:0] disch_time, t_sens, t_ref, n_start, n_nopost, n_post, n_temp;
   wire meas_start, with_temp, post_en, meas_done, spd_bad, irq;
   wire [1:0] spd1, spd2;
   integer errors = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   integer k, t0, t1;
   ssq_sequencer dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_measure_opcode(start_op),
      .init_opcode(init_op), .meas_start(meas_start), .meas_with_temp(with_temp), .post_process_en(post_en),
      .meas_done(meas_done), .meas_value(meas_value), .disch_time(disch_time), .temp_sensor_time(t_sens),
      .temp_ref_time(t_ref), .first_arith_ram_req(ram_req[0]), .second_arith_ram_req(ram_req[1]),
      .first_arith_speed(spd1), .second_arith_speed(spd2), .speed_unsupported(spd_bad), .irq(irq));
   ssq_meas_model u_fe (.clk_sys(clk_sys), .rstn(rstn), .init_opcode(init_op), .meas_start(meas_start),
      .meas_with_temp(with_temp), .post_process_en(post_en), .val(m_val), .dis(m_dis), .ts(m_ts),
      .tr(16'h2000), .meas_done(meas_done), .meas_value(meas_value), .disch_time(disch_time),
      .temp_sensor_time(t_sens), .temp_ref_time(t_ref), .n_start(n_start), .n_nopost(n_nopost),
      .n_post(n_post), .n_temp(n_temp));
   // Clock and the hang guard.
   initial forever #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (ram_req == 2'h3) ram_req <= 2'h0;
      if (cyc == 60000) begin
         errors = errors + 1;
         conclude;
      end
   end
   task conclude;
      begin
         if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input [8*8:1] nm, input [23:0] e, input [23:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [3:0] a, input [23:0] d);
      begin
         @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
         @(posedge clk_sys) reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a);
      begin
         @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
         @(posedge clk_sys) reg_rd <= 1'b0;
         #1 q = reg_rdata;
      end
   endtask
   task pulse_init;
      begin
         @(posedge clk_sys) init_op <= 1'b1;
         @(posedge clk_sys) init_op <= 1'b0;
      end
   endtask
   task start_pulse;
      begin
         @(posedge clk_sys) start_op <= 1'b1;
         @(posedge clk_sys) start_op <= 1'b0;
      end
   endtask
   task wait_post(input integer n);
      begin
         t0 = n_post + n;
         while (n_post < t0) @(posedge clk_sys);
      end
   endtask
   // Main sequence.
   initial begin
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(4'h0); chk("cfg0", 24'h000502, q);
      rd(4'h1); chk("unmap", 24'h000000, q);
      wr(4'h0, 24'h000002);
      #1 chk("unsup", 24'h000001, {23'h0, spd_bad});
      wr(4'h6, 24'h000008);
      for (k = 0; k < 4; k = k + 1) begin
         m_val <= 24'h000100;
         wr(4'h0, 24'h000580);
         wr(4'h2, (k << 4) | (k << 8) | (k << 12));
         pulse_init;
         rd(4'h5);
         start_pulse;
         while (irq !== 1'b1) @(posedge clk_sys);
         #1 chk("starts", ((k == 0) ? 0 : (8 << k)) + ((k == 3) ? 4 : k) + (1 << k), n_start);
         chk("nopost", ((k == 0) ? 0 : (8 << k)) + ((k == 3) ? 4 : k), n_nopost);
         rd(4'h4); chk("offset", 24'h000100, q);
         rd(4'h5); chk("offrdy", 24'h000008, q & 24'h000008);
         m_val <= 24'h000150;
         wait_post(2);
         rd(4'h3); chk("result", 24'h000050, q);
         rd(4'h5); chk("clear", 24'h000000, q & 24'h000008);
         chk("irq", 24'h000000, {23'h0, irq});
      end
      m_val <= 24'h0001F0;
      m_dis <= 16'h000E;
      wait_post(2);
      rd(4'h3); chk("tmo_res", 24'h000050, q);
      rd(4'h5); chk("tmo_irq", 24'h000002, q & 24'h000002);
      m_dis <= 16'h000F;
      wait_post(1);
      rd(4'h5);
      wait_post(2);
      rd(4'h5); chk("tmo_off", 24'h000000, q & 24'h000002);
      rd(4'h3); chk("res_ok", 24'h0000F0, q);
      for (k = 0; k < 4; k = k + 1) begin
         wr(4'h0, 24'h000580 | (k << 1));
         wait_post(2);
         t1 = n_temp;
         wait_post(18);
         chk("temps", (k == 0) ? 0 : (k == 1) ? 18 : (k == 2) ? 3 : 2, n_temp - t1);
      end
      rd(4'h2); chk("temp", 24'h002000, q);
      wr(4'h0, 24'h000580);
      wait_post(1);
      m_ts <= 16'h3000;
      wait_post(3);
      rd(4'h2); chk("hold", 24'h002000, q);
      wr(4'h0, 24'h000582);
      wait_post(3);
      rd(4'h2); chk("temp2", 24'h006000, q);
      @(posedge clk_sys) ram_req <= 2'h3;
      rd(4'h2); chk("confl", 24'h086000, q);
      rd(4'h5); chk("conf_irq", 24'h000004, q & 24'h000004);
      pulse_init;
      rd(4'h2); chk("conf_clr", 24'h000000, q & 24'h080000);
      wr(4'h2, 24'h000010);
      wr(4'h0, 24'h000581);
      wr(4'h6, 24'h000001);
      pulse_init;
      rd(4'h5);
      for (k = 0; k < 3; k = k + 1) begin
         start_pulse;
         wait_post(1);
         repeat (40) @(posedge clk_sys);
         #1 chk("single", {23'h0, k == 2}, {23'h0, irq});
      end
      conclude;
   end
endmodule // ssq_sequencer_test
